//--- hdl/ubc_cfg.svh
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH

// ----------------------------------------------------------------
// Register map (word addresses on the byte address bus)
// ----------------------------------------------------------------
`define UBC_ADDR_CTRL       8'h00
`define UBC_ADDR_MODE       8'h04
`define UBC_ADDR_BAUD       8'h08
`define UBC_ADDR_ETU        8'h0c
`define UBC_ADDR_STAT       8'h10

// ----------------------------------------------------------------
// Control register command bits
// ----------------------------------------------------------------
`define UBC_CTRL_RXRST      2
`define UBC_CTRL_TXRST      3
`define UBC_CTRL_RECEIVER_ENABLE_CMD       4
`define UBC_CTRL_RECEIVER_DISABLE_CMD      5
`define UBC_CTRL_TRANSMITTER_ENABLE_CMD       6
`define UBC_CTRL_TRANSMITTER_DISABLE_CMD      7

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define UBC_MODE_SYNC       0
`define UBC_MODE_ISO        1
`define UBC_MODE_CLKS_LO    4
`define UBC_MODE_CLKS_HI    5
`define UBC_MODE_HALF       6
`define UBC_MODE_CKO        7

// ----------------------------------------------------------------
// Baud generator and bit-time ratio fields
// ----------------------------------------------------------------
`define UBC_BAUD_CD_HI      15
`define UBC_BAUD_FP_LO      16
`define UBC_BAUD_FP_HI      18
`define UBC_ETU_HI          10

// ----------------------------------------------------------------
// Source selects, constants and reset values
// ----------------------------------------------------------------
`define UBC_CLKS_MCK        2'h0
`define UBC_CLKS_DIV        2'h1
`define UBC_CLKS_EXT        2'h3
`define UBC_MCK_DIV_LAST    3'h7
`define UBC_OVS16_LAST      4'hf
`define UBC_OVS8_LAST       4'h7
`define UBC_ETU_RESET       11'h174
`define UBC_CD_OFF          16'h0000
`define UBC_CD_BYPASS       16'h0001
`define UBC_FP_NONE         3'h0

`endif

//--- hdl/ubc_pkg.sv
`include "ubc_cfg.svh"

package ubc_pkg;

	typedef enum logic [2:0] {
		UBC_DIR_OFF   = 3'b001,
		UBC_DIR_ON    = 3'b010,
		UBC_DIR_DRAIN = 3'b100
	} ubc_dir_state_t;

	typedef struct packed {
		ubc_dir_state_t st;
		logic           rst_p;
	} ubc_dir_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [2:0]  acc;
		logic        stretch;
		logic        tick;
		logic        lvl;
	} ubc_div_t;

	typedef struct packed {
		logic        sync_mode;
		logic        iso_mode;
		logic [1:0]  clock_source_select;
		logic        half_sampling_select;
		logic        card_clock_output;
		logic [15:0] clock_divisor;
		logic [2:0]  fractional_part;
		logic [10:0] etu_divider_ratio;
		logic [31:0] rdata;
		logic [2:0]  mck_div;
		logic        mck_div_tick;
		logic        sck_prev;
		logic [3:0]  ovs_cnt;
		logic [10:0] etu_cnt;
		logic        sample_tick;
		logic        bit_tick;
	} ubc_top_t;

endpackage

//--- hdl/ubc_dir_ctl.sv
`include "ubc_cfg.svh"

module ubc_dir_ctl
	import ubc_pkg::*;
(
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic en_cmd,
	input  wire logic dis_cmd,
	input  wire logic rst_cmd,
	input  wire logic work_busy,
	output logic      enabled,
	output logic      draining,
	output logic      soft_rst
);

	ubc_dir_t s_q;
	ubc_dir_t s_d;

	// ----------------------------------------------------------------
	// Enable, disable and soft reset of one direction
	// ----------------------------------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.rst_p = 1'b0;
		if (rst_cmd) begin
			// Stops at once, whatever is in flight
			s_d.st    = UBC_DIR_OFF; // RQ19
			s_d.rst_p = 1'b1; // RQ19
		end else begin
			unique case (s_q.st)
				UBC_DIR_OFF: begin
					if (en_cmd && !dis_cmd) begin
						s_d.st = UBC_DIR_ON; // RQ16 RQ17 RQ26
					end
				end
				UBC_DIR_ON: begin
					if (dis_cmd) begin
						s_d.st = work_busy ? UBC_DIR_DRAIN : UBC_DIR_OFF; // RQ20 RQ21 RQ26
					end
				end
				UBC_DIR_DRAIN: begin
					if (en_cmd && !dis_cmd) begin
						s_d.st = UBC_DIR_ON;
					end else if (!work_busy) begin
						s_d.st = UBC_DIR_OFF; // RQ20 RQ21
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: UBC_DIR_OFF, rst_p: 1'b0}; // RQ16 RQ17
		end else begin
			s_q <= s_d;
		end
	end

	assign enabled  = (s_q.st != UBC_DIR_OFF);
	assign draining = (s_q.st == UBC_DIR_DRAIN);
	assign soft_rst = s_q.rst_p;

endmodule

//--- hdl/ubc_frac_div.sv
`include "ubc_cfg.svh"

module ubc_frac_div
	import ubc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        src_en,
	input  wire logic [15:0] clock_divisor,
	input  wire logic [2:0]  fractional_part,
	input  wire logic        frac_on,
	output logic             tick,
	output logic             lvl
);

	ubc_div_t s_q;
	ubc_div_t s_d;

	logic [15:0] last;
	logic [15:0] half;
	logic [3:0]  acc_sum;

	// ----------------------------------------------------------------
	// Divide the source by divisor plus fraction over eight
	// ----------------------------------------------------------------
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		last     = clock_divisor - 16'h0001 + {15'h0000, s_q.stretch};
		half     = clock_divisor >> 1;
		acc_sum  = {1'b0, s_q.acc} + {1'b0, fractional_part};
		if (clock_divisor == `UBC_CD_OFF) begin
			s_d.cnt     = '0; // RQ22
			s_d.acc     = '0;
			s_d.stretch = 1'b0;
			s_d.lvl     = 1'b0;
		end else if (clock_divisor == `UBC_CD_BYPASS) begin
			// Bypass: every source pulse is an output pulse
			s_d.tick = src_en; // RQ22
			if (src_en) begin
				s_d.lvl = !s_q.lvl;
			end
		end else if (src_en) begin
			if (s_q.cnt >= last) begin
				s_d.cnt  = '0;
				s_d.tick = 1'b1;
				s_d.lvl  = 1'b1;
				// Carry out of the eighths adds one source period
				if (frac_on && fractional_part != `UBC_FP_NONE) begin
					s_d.acc     = acc_sum[2:0]; // RQ1 RQ2
					s_d.stretch = acc_sum[3]; // RQ2
				end else begin
					s_d.acc     = '0; // RQ1 RQ3
					s_d.stretch = 1'b0;
				end
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
				if (s_q.cnt + 16'h0001 == half) begin
					s_d.lvl = 1'b0; // RQ8
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
	assign lvl  = s_q.lvl;

endmodule

//--- hdl/ubc_top.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "ubc_cfg.svh"

// Notes on behaviour
// RQ1 - Nonzero fractional part turns on fractional division; zero means plain integer divide.
// RQ2 - Fraction step is one eighth; divisor is clock_divisor plus fractional_part/8.
// RQ3 - Fractional division only in normal serial mode, never in smart card mode.
// RQ4 - Asynchronous bit rate is source over 8*(2-half)*(divisor+fraction/8).
// RQ5 - Synchronous bit clock is source divided by clock_divisor only.
// RQ6 - Synchronous with external source: serial clock pin is the bit clock, undivided.
// RQ7 - External serial clock must be at least 4.5 times slower than master clock.
// RQ8 - With master clock source, serial clock output aims at even duty.
// RQ9 - Software picks even divisor for even duty with divided or external source.
// RQ10 - Rate adjust code table is software's concern for the ratio.
// RQ11 - Clock division code table is software's concern for the ratio.
// RQ12 - Smart card mode divides source by divisor, optionally drives it on pin.
// RQ13 - Bit-time divider divides card clock by etu ratio, up to 2047.
// RQ14 - Software programs the nearest integer etu ratio.
// RQ15 - Etu ratio resets to 0x174, which is 372.
// RQ16 - Receiver starts disabled; enabled only by command; config writable meanwhile.
// RQ17 - Transmitter starts disabled; enabled only by command; config writable meanwhile.
// RQ18 - Receiver and transmitter enable together or apart, independently.
// RQ19 - Direction reset command acts as hardware reset and stops at once.
// RQ20 - Receiver disable waits for the character in progress.
// RQ21 - Transmitter disable waits for shifted and held characters and timeguard.
// RQ22 - Divisor zero gives no clock; divisor one bypasses the divider.
// RQ23 - Half sampling selects 8 times oversampling, else 16 times.
// RQ24 - Source select picks master clock, master clock over 8, or serial pin.
// RQ25 - Command bits act only when written one and are never stored.
// RQ26 - Enable and disable written together: disable wins.
module ubc_top
	import ubc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        rx_busy,
	input  wire logic        tx_busy,
	input  wire logic        tx_holding_full,
	input  wire logic        tx_guard_busy,
	output logic             sample_tick,
	output logic             bit_tick,
	output logic             rx_enabled,
	output logic             tx_enabled,
	output logic             rx_soft_rst,
	output logic             tx_soft_rst
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic cmd(input logic wr, input logic [31:0] d, input int bitpos);
		cmd = wr && d[bitpos];
	endfunction

	ubc_top_t s_q;
	ubc_top_t s_d;

	logic        ctrl_wr;
	logic        rx_en_cmd;
	logic        rx_dis_cmd;
	logic        rx_rst_cmd;
	logic        tx_en_cmd;
	logic        tx_dis_cmd;
	logic        tx_rst_cmd;
	logic        rx_draining;
	logic        tx_draining;
	logic        tx_work;
	logic        src_en;
	logic        sck_rise;
	logic        frac_on;
	logic        div_tick;
	logic        div_lvl;
	logic        ext_sync;
	logic [3:0]  ovs_last;
	logic [31:0] rd_word;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Commands are pulses straight from the write; nothing is kept
	assign ctrl_wr    = reg_wr && hit(reg_addr, `UBC_ADDR_CTRL);
	assign rx_en_cmd  = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_RECEIVER_ENABLE_CMD); // RQ25
	assign rx_dis_cmd = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_RECEIVER_DISABLE_CMD); // RQ25
	assign rx_rst_cmd = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_RXRST); // RQ25
	assign tx_en_cmd  = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_TRANSMITTER_ENABLE_CMD); // RQ25
	assign tx_dis_cmd = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_TRANSMITTER_DISABLE_CMD); // RQ25
	assign tx_rst_cmd = cmd(ctrl_wr, reg_wdata, `UBC_CTRL_TXRST); // RQ25

	// Transmitter drains shifter, holding register and guard time
	assign tx_work = tx_busy || tx_holding_full || tx_guard_busy; // RQ21

	// ----------------------------------------------------------------
	// Direction control, one instance each so they never interact
	// ----------------------------------------------------------------
	ubc_dir_ctl u_rx_ctl ( // RQ18
		.clk       (clk),
		.nrst      (nrst),
		.en_cmd    (rx_en_cmd),
		.dis_cmd   (rx_dis_cmd),
		.rst_cmd   (rx_rst_cmd),
		.work_busy (rx_busy),
		.enabled   (rx_enabled),
		.draining  (rx_draining),
		.soft_rst  (rx_soft_rst)
	);

	ubc_dir_ctl u_tx_ctl ( // RQ18
		.clk       (clk),
		.nrst      (nrst),
		.en_cmd    (tx_en_cmd),
		.dis_cmd   (tx_dis_cmd),
		.rst_cmd   (tx_rst_cmd),
		.work_busy (tx_work),
		.enabled   (tx_enabled),
		.draining  (tx_draining),
		.soft_rst  (tx_soft_rst)
	);

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	// Pin is synchronous to clk, so one stage of history finds the edge
	assign sck_rise = sck_i && !s_q.sck_prev;

	always_comb begin
		unique case (s_q.clock_source_select)
			`UBC_CLKS_MCK: src_en = 1'b1; // RQ24
			`UBC_CLKS_EXT: src_en = sck_rise; // RQ24
			default:       src_en = s_q.mck_div_tick; // RQ24
		endcase
	end

	// Fraction only in plain asynchronous serial mode
	assign frac_on  = !s_q.sync_mode && !s_q.iso_mode; // RQ3
	assign ext_sync = s_q.sync_mode && !s_q.iso_mode
		&& (s_q.clock_source_select == `UBC_CLKS_EXT); // RQ6
	assign ovs_last = s_q.half_sampling_select ? `UBC_OVS8_LAST : `UBC_OVS16_LAST; // RQ23

	ubc_frac_div u_div (
		.clk             (clk),
		.nrst            (nrst),
		.src_en          (src_en),
		.clock_divisor   (s_q.clock_divisor),
		.fractional_part (s_q.fractional_part),
		.frac_on         (frac_on),
		.tick            (div_tick),
		.lvl             (div_lvl)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		if (hit(reg_addr, `UBC_ADDR_MODE)) begin
			rd_word[`UBC_MODE_SYNC]                     = s_q.sync_mode;
			rd_word[`UBC_MODE_ISO]                      = s_q.iso_mode;
			rd_word[`UBC_MODE_CLKS_HI:`UBC_MODE_CLKS_LO] = s_q.clock_source_select;
			rd_word[`UBC_MODE_HALF]                     = s_q.half_sampling_select;
			rd_word[`UBC_MODE_CKO]                      = s_q.card_clock_output;
		end else if (hit(reg_addr, `UBC_ADDR_BAUD)) begin
			rd_word[`UBC_BAUD_CD_HI:0]                  = s_q.clock_divisor;
			rd_word[`UBC_BAUD_FP_HI:`UBC_BAUD_FP_LO]    = s_q.fractional_part;
		end else if (hit(reg_addr, `UBC_ADDR_ETU)) begin
			rd_word[`UBC_ETU_HI:0]                      = s_q.etu_divider_ratio;
		end else if (hit(reg_addr, `UBC_ADDR_STAT)) begin
			rd_word[0] = rx_enabled;
			rd_word[1] = tx_enabled;
			rd_word[2] = rx_draining;
			rd_word[3] = tx_draining;
		end
	end

	// ----------------------------------------------------------------
	// Registers and rate chain
	// ----------------------------------------------------------------
	always_comb begin
		s_d              = s_q;
		s_d.sample_tick  = 1'b0;
		s_d.bit_tick     = 1'b0;
		s_d.mck_div_tick = 1'b0;
		s_d.sck_prev     = sck_i;

		// Configuration stays writable whether or not a direction runs
		if (reg_wr && hit(reg_addr, `UBC_ADDR_MODE)) begin
			s_d.sync_mode            = reg_wdata[`UBC_MODE_SYNC];
			s_d.iso_mode             = reg_wdata[`UBC_MODE_ISO];
			s_d.clock_source_select  = reg_wdata[`UBC_MODE_CLKS_HI:`UBC_MODE_CLKS_LO];
			s_d.half_sampling_select = reg_wdata[`UBC_MODE_HALF];
			s_d.card_clock_output    = reg_wdata[`UBC_MODE_CKO];
		end
		if (reg_wr && hit(reg_addr, `UBC_ADDR_BAUD)) begin
			s_d.clock_divisor   = reg_wdata[`UBC_BAUD_CD_HI:0]; // RQ16 RQ17
			s_d.fractional_part = reg_wdata[`UBC_BAUD_FP_HI:`UBC_BAUD_FP_LO];
		end
		if (reg_wr && hit(reg_addr, `UBC_ADDR_ETU)) begin
			s_d.etu_divider_ratio = reg_wdata[`UBC_ETU_HI:0];
		end
		if (reg_rd) begin
			s_d.rdata = rd_word;
		end

		// Fixed master clock prescaler
		s_d.mck_div = s_q.mck_div + 3'h1;
		if (s_q.mck_div == `UBC_MCK_DIV_LAST) begin
			s_d.mck_div_tick = 1'b1; // RQ24
		end

		if (s_q.iso_mode) begin
			// Card clock pulses count out one elementary time unit
			s_d.sample_tick = div_tick; // RQ12
			if (div_tick) begin
				if (s_q.etu_divider_ratio != '0
					&& s_q.etu_cnt + 11'h001 >= s_q.etu_divider_ratio) begin
					s_d.etu_cnt  = '0;
					s_d.bit_tick = 1'b1; // RQ13
				end else begin
					s_d.etu_cnt = s_q.etu_cnt + 11'h001; // RQ13
				end
			end
		end else if (s_q.sync_mode) begin
			// Divider value is irrelevant with an external bit clock
			s_d.bit_tick    = ext_sync ? sck_rise : div_tick; // RQ5 RQ6
			s_d.sample_tick = s_d.bit_tick;
		end else begin
			s_d.sample_tick = div_tick; // RQ4
			if (div_tick) begin
				if (s_q.ovs_cnt >= ovs_last) begin
					s_d.ovs_cnt  = '0;
					s_d.bit_tick = 1'b1; // RQ4 RQ23
				end else begin
					s_d.ovs_cnt = s_q.ovs_cnt + 4'h1;
				end
			end
		end
		if (!s_q.iso_mode) begin
			s_d.etu_cnt = '0;
		end
		if (s_q.iso_mode || s_q.sync_mode) begin
			s_d.ovs_cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q                   <= '0;
			s_q.etu_divider_ratio <= `UBC_ETU_RESET; // RQ15
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Card clock on the pin only when asked; sync master drives its own bit clock
	assign sck_oe      = s_q.iso_mode ? s_q.card_clock_output // RQ12
		: (s_q.sync_mode && !ext_sync);
	assign sck_o       = sck_oe && div_lvl; // RQ8 RQ12
	assign reg_rdata   = s_q.rdata;
	assign sample_tick = s_q.sample_tick;
	assign bit_tick    = s_q.bit_tick;

endmodule

//--- testbench/ubc_top_chk.sv
`include "ubc_cfg.svh"

module ubc_top_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        sck_i,
	input wire logic        sck_o,
	input wire logic        sck_oe,
	input wire logic        rx_busy,
	input wire logic        tx_busy,
	input wire logic        tx_holding_full,
	input wire logic        tx_guard_busy,
	input wire logic        sample_tick,
	input wire logic        bit_tick,
	input wire logic        rx_enabled,
	input wire logic        tx_enabled,
	input wire logic        rx_soft_rst,
	input wire logic        tx_soft_rst
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// Shadow of mode and divisor
	// ------------------------------------------------
	logic [7:0]  mode_q;
	logic [15:0] cd_q;
	logic        wr_ctl;
	logic        ext_on;
	logic        tx_hold;
	assign wr_ctl = reg_wr && reg_addr == `UBC_ADDR_CTRL;
	// Smart card mode keeps its own divider chain even with the pin source selected
	assign ext_on = mode_q[`UBC_MODE_SYNC] && !mode_q[`UBC_MODE_ISO]
		&& mode_q[5:4] == `UBC_CLKS_EXT;
	assign tx_hold = tx_busy || tx_holding_full || tx_guard_busy;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= 8'h00;
			cd_q   <= 16'h0000;
		end else if (reg_wr && reg_addr == `UBC_ADDR_MODE) begin
			mode_q <= reg_wdata[7:0];
		end else if (reg_wr && reg_addr == `UBC_ADDR_BAUD) begin
			cd_q <= reg_wdata[15:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_rx_soft_rst: assert property (
		wr_ctl && reg_wdata[`UBC_CTRL_RXRST] |=> rx_soft_rst && !rx_enabled) else $error("rx reset");
	a_rx_en_cause: assert property (
		$rose(rx_enabled) |-> $past(wr_ctl) && $past(reg_wdata[4])) else $error("rx self start");
	a_tx_en_cause: assert property (
		$rose(tx_enabled) |-> $past(wr_ctl) && $past(reg_wdata[6])) else $error("tx self start");
	a_dis_wins: assert property (
		wr_ctl && reg_wdata[4] && reg_wdata[5] && !rx_enabled |=> !rx_enabled) else $error("rx on");
	a_rx_drain: assert property (
		$fell(rx_enabled) |-> !$past(rx_busy) || rx_soft_rst) else $error("rx cut short");
	a_tx_drain: assert property (
		$fell(tx_enabled) |-> !$past(tx_hold) || tx_soft_rst) else $error("tx cut short");
	a_cd_quiet: assert property (
		cd_q == 16'h0000 && $past(cd_q) == 16'h0000 && $past(cd_q, 2) == 16'h0000 && !ext_on
		&& !$past(ext_on) |-> !sample_tick && !bit_tick) else $error("tick with divisor zero");
	a_ext_bit: assert property (
		ext_on && $past(ext_on) && $rose(sck_i) |=> bit_tick) else $error("ext edge lost");
	a_ctrl_read0: assert property (
		reg_rd && reg_addr == `UBC_ADDR_CTRL |=> reg_rdata == 32'h0) else $error("ctrl stored");
	a_cko_drive: assert property (
		mode_q[`UBC_MODE_ISO] && mode_q[`UBC_MODE_CKO] |-> sck_oe) else $error("card clock off");
	a_bit_on_sample: assert property (
		bit_tick |-> sample_tick) else $error("bit tick without sample tick");
	c_rx_drain: cover property ($fell(rx_enabled) && !rx_soft_rst);
	c_ext_tick: cover property (ext_on && bit_tick);
	c_card_clk: cover property (sck_oe && $rose(sck_o));
endmodule

bind ubc_top ubc_top_chk i_ubc_top_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .rx_busy(rx_busy), .tx_busy(tx_busy),
	.tx_holding_full(tx_holding_full), .tx_guard_busy(tx_guard_busy),
	.sample_tick(sample_tick), .bit_tick(bit_tick), .rx_enabled(rx_enabled),
	.tx_enabled(tx_enabled), .rx_soft_rst(rx_soft_rst), .tx_soft_rst(tx_soft_rst));

//--- testbench/ubc_far_model.sv
module ubc_far_model #(
	parameter int HALF = 4
) (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic sck_o,
	input  wire logic sck_oe,
	output logic      sck_i,
	output int        card_edges
);
	timeunit 1ns;
	timeprecision 1ns;
	int   ph = 0;
	logic ext = 1'b0;
	logic prev = 1'b0;
	// Pin level: the block wins while it drives, else the far clock
	assign sck_i = sck_oe ? sck_o : ext;
	initial card_edges = 0;
	always @(posedge clk) begin
		ph <= run ? (ph + 1) % HALF : 0;
		// Period 2*HALF cycles, far slower than the master clock; still when idle
		if (!run) ext <= 1'b0; else if (ph == HALF - 1) ext <= ~ext;
		prev <= sck_oe && sck_o;
		if (sck_oe && sck_o && !prev) card_edges <= card_edges + 1;
	end
endmodule

//--- testbench/test_usart_baud_and_txrx_control.sv
`include "ubc_cfg.svh"

module test_usart_baud_and_txrx_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_CTL = `UBC_ADDR_CTRL;
	localparam logic [7:0] A_MOD = `UBC_ADDR_MODE;
	localparam logic [7:0] A_BRG = `UBC_ADDR_BAUD;
	localparam logic [7:0] A_ETU = `UBC_ADDR_ETU;
	localparam logic [7:0] A_STA = `UBC_ADDR_STAT;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rx_busy = 1'b0;
	logic        tx_busy = 1'b0;
	logic        tx_holding_full = 1'b0;
	logic        tx_guard_busy = 1'b0;
	logic        run = 1'b0;
	logic [31:0] reg_rdata;
	logic        sck_i, sck_o, sck_oe, sample_tick, bit_tick;
	logic        rx_enabled, tx_enabled, rx_soft_rst, tx_soft_rst;
	int          card_edges;
	int          error_cnt = 0;
	int          total_checks = 0;

	always #25 clk = ~clk;

	ubc_top i_ubc_top (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe), .rx_busy(rx_busy), .tx_busy(tx_busy), .tx_holding_full(tx_holding_full),
		.tx_guard_busy(tx_guard_busy), .sample_tick(sample_tick), .bit_tick(bit_tick),
		.rx_enabled(rx_enabled), .tx_enabled(tx_enabled), .rx_soft_rst(rx_soft_rst),
		.tx_soft_rst(tx_soft_rst));
	ubc_far_model i_ubc_far_model (.clk(clk), .run(run), .sck_o(sck_o), .sck_oe(sck_oe),
		.sck_i(sck_i), .card_edges(card_edges));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic step(input logic [31:0] c, input logic [31:0] s);
		wr(A_CTL, c);
		rd_chk(A_STA, s);
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (bit_tick !== 1'b1 && n < 5000);
	endtask
	// Two ticks are thrown away so a partial count from the old setup is not measured
	task automatic rate(input logic [7:0] m, input logic [31:0] b, input logic [31:0] e,
		input int per, input int edg);
		int n;
		int c0;
		wr(A_MOD, {24'h0, m});
		wr(A_BRG, b);
		wr(A_ETU, e);
		run <= (m[5:4] == 2'h3);
		wait_tick(n);
		wait_tick(n);
		c0 = card_edges;
		wait_tick(n);
		chk(32'(n), 32'(per));
		if (edg != 0)
			chk(32'(card_edges - c0), 32'(edg));
		@(posedge clk) run <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end

	initial begin
		int n;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(A_ETU, 32'h174);
		rd_chk(A_BRG, 32'h0);
		rd_chk(8'h14, 32'h0);
		n = 0;
		repeat (64) begin
			@(posedge clk);
			if (sample_tick !== 1'b0 || bit_tick !== 1'b0) n++;
		end
		chk(32'(n), 32'h0);
		wr(A_ETU, 32'h5);
		rd_chk(A_ETU, 32'h5);
		@(posedge clk) nrst <= 1'b0;
		@(posedge clk) nrst <= 1'b1;
		rd_chk(A_ETU, 32'h174);
		$display("test reset done");
		rd_chk(A_STA, 32'h0);
		step(32'h10, 32'h1);
		step(32'h40, 32'h3);
		step(32'h00, 32'h3);
		rd_chk(A_CTL, 32'h0);
		step(32'ha0, 32'h0);
		step(32'hf0, 32'h0);
		step(32'h50, 32'h3);
		$display("test enable done");
		@(posedge clk);
		rx_busy <= 1'b1;
		tx_holding_full <= 1'b1;
		tx_guard_busy <= 1'b1;
		step(32'ha0, 32'hf);
		@(posedge clk);
		rx_busy <= 1'b0;
		tx_holding_full <= 1'b0;
		repeat (2) @(posedge clk);
		rd_chk(A_STA, 32'ha);
		@(posedge clk) tx_guard_busy <= 1'b0;
		repeat (2) @(posedge clk);
		rd_chk(A_STA, 32'h0);
		step(32'h50, 32'h3);
		@(posedge clk);
		rx_busy <= 1'b1;
		tx_busy <= 1'b1;
		wr(A_CTL, 32'h0c);
		#1 chk({30'h0, rx_soft_rst, tx_soft_rst}, 32'h3);
		rd_chk(A_STA, 32'h0);
		@(posedge clk);
		rx_busy <= 1'b0;
		tx_busy <= 1'b0;
		$display("test control done");
		rate(8'h00, 32'h0000_0003, 32'h174, 48, 0);
		rate(8'h00, 32'h0004_0003, 32'h174, 56, 0);
		rate(8'h40, 32'h0003_0003, 32'h174, 27, 0);
		rate(8'h01, 32'h0004_0005, 32'h174, 5, 0);
		rate(8'h01, 32'h0000_0001, 32'h174, 1, 0);
		rate(8'h11, 32'h0000_0002, 32'h174, 16, 0);
		rate(8'h82, 32'h0004_0003, 32'h005, 15, 5);
		rate(8'h02, 32'h0000_0001, 32'h7ff, 2047, 0);
		rate(8'h02, 32'h0000_0001, 32'h174, 372, 0);
		rate(8'h31, 32'h0000_0009, 32'h174, 8, 0);
		$display("test rate done");
		report_and_stop;
	end
endmodule
